/* File: rtl/uart_shadow_pkg.sv */
// Constants shared by the UART shadow data port
package uart_shadow_pkg;

   // ****************************************
   // Widths and depths
   // ****************************************
   localparam int CHAR_WIDTH = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int IRQ_WIDTH = 4;

   // ****************************************
   // Register map, byte addresses
   // ****************************************
   localparam logic [31:0] SHADOW12_OFFSET = 32'h5000_1060;
   localparam int SHADOW12_INDEX = 12;
   localparam logic [31:0] SHADOW_STRIDE = 32'h0000_0004;
   localparam logic [31:0] SHADOW_SPAN = 32'h0000_0040;
   localparam logic [31:0] SHADOW_BASE =
      SHADOW12_OFFSET - SHADOW_STRIDE * 32'(SHADOW12_INDEX);
   localparam logic [31:0] CTRL_OFFSET = 32'h5000_1100;
   localparam logic [31:0] LINE_STATUS_OFFSET = 32'h5000_1104;
   localparam logic [31:0] IRQ_STATUS_OFFSET = 32'h5000_1108;
   localparam logic [31:0] IRQ_MASK_OFFSET = 32'h5000_110C;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CTRL_FIFO_EN_BIT = 0;
   localparam int CTRL_IR_MODE_BIT = 1;
   localparam int LS_DATA_READY_BIT = 0;
   localparam int LS_OVERRUN_BIT = 1;
   localparam int LS_HOLD_EMPTY_BIT = 5;
   localparam int IRQ_RX_CHAR_BIT = 0;
   localparam int IRQ_OVERRUN_BIT = 1;
   localparam int IRQ_TX_DROP_BIT = 2;
   localparam int IRQ_HOLD_EMPTY_BIT = 3;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic FIFO_EN_RESET = 1'b0;
   localparam logic IR_MODE_RESET = 1'b0;
   localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

endpackage

/* File: rtl/uart_char_fifo.sv */
// Character FIFO in flip-flops, used for both receive and transmit
`timescale 1ns/1ps
module uart_char_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Requests
   input wire logic clear,
   input wire logic push,
   input wire logic pop,
   input wire logic [WIDTH-1:0] din,
   // State
   output logic [WIDTH-1:0] head,
   output logic [$clog2(DEPTH+1)-1:0] count,
   output logic full,
   output logic empty
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0] rd_ptr;
   logic [PW-1:0] wr_ptr;
   logic do_pop;
   logic do_push;

   function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
      next_ptr = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   assign empty = (count == '0);
   assign full = (count == CW'(DEPTH));
   assign head = store[rd_ptr];
   assign do_pop = pop && !empty;
   // A full FIFO still takes a push when the same edge pops
   assign do_push = push && (!full || do_pop);

   always_ff @(posedge clock) begin
      if (rst || clear) begin
         rd_ptr <= '0;
         wr_ptr <= '0;
         count <= '0;
      end else begin
         if (do_pop) begin
            rd_ptr <= next_ptr(rd_ptr);
         end
         if (do_push) begin
            wr_ptr <= next_ptr(wr_ptr);
         end
         count <= count + CW'(do_push) - CW'(do_pop);
      end
   end

   // Data storage needs no reset
   always_ff @(posedge clock) begin
      if (do_push) begin
         store[wr_ptr] <= din;
      end
   end

endmodule

/* File: rtl/uart_shadow_data_port.sv */
// UART shadow receive/transmit data port with Avalon-MM register slave
//
// Operation
// - A shadow read returns in its low byte the character from the serial or infrared input.
// - Sixteen word locations all alias the receive buffer and transmit holding register.
// - With FIFOs off a new character overwrites an unread one and raises overrun.
// - With FIFOs on a shadow read returns the oldest character of the receive FIFO.
// - A character arriving at a full receive FIFO with no shadow read popping on that edge is dropped, the FIFO kept, overrun raised.
// - A shadow write supplies the byte sent on the serial or the infrared output.
// - With FIFOs off a write while holding-empty is set clears that flag.
// - With FIFOs off a further write before holding-empty returns replaces the byte.
// - With FIFOs on the transmit FIFO takes its configured depth, 16 by default.
// - A write into a full transmit FIFO with no load on the same edge is lost and the queue is untouched.
`timescale 1ns/1ps
module uart_shadow_data_port #(
   parameter int FIFO_DEPTH = uart_shadow_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST,
   // Avalon-MM slave
   input wire logic [31:0] ADDRESS,
   input wire logic READ,
   input wire logic WRITE,
   input wire logic [31:0] WRITEDATA,
   input wire logic [3:0] BYTEENABLE,
   output logic [31:0] READDATA,
   output logic WAITREQUEST,
   // Received characters
   input wire logic UART_RX_VALID,
   input wire logic [uart_shadow_pkg::CHAR_WIDTH-1:0] UART_RX_DATA,
   input wire logic IR_RX_VALID,
   input wire logic [uart_shadow_pkg::CHAR_WIDTH-1:0] IR_RX_DATA,
   // Characters to send
   input wire logic TX_TAKE,
   output logic TX_UART_VALID,
   output logic TX_IR_VALID,
   output logic [uart_shadow_pkg::CHAR_WIDTH-1:0] TX_DATA,
   // Interrupt
   output logic IRQ
);
   localparam int CW = $clog2(FIFO_DEPTH + 1);
   localparam int DW = uart_shadow_pkg::CHAR_WIDTH;
   localparam int IW = uart_shadow_pkg::IRQ_WIDTH;

   // ****************************************
   // Declarations
   // ****************************************
   logic req;
   logic fire;
   logic hit_shadow;
   logic rd_ok;
   logic fifo_en;
   logic ir_mode;
   logic fifo_clear;
   logic [31:0] rd_value;
   logic [7:0] line_status;
   logic rx_in_valid;
   logic [DW-1:0] rx_in_data;
   logic [DW-1:0] rx_hold;
   logic rx_hold_valid;
   logic [DW-1:0] rx_head;
   logic [CW-1:0] rx_count;
   logic rx_full;
   logic rx_empty;
   logic rx_pop;
   logic data_ready;
   logic overrun_event;
   logic overrun;
   logic tx_wr;
   logic [DW-1:0] tx_hold;
   logic tx_hold_valid;
   logic [DW-1:0] tx_head;
   logic [CW-1:0] tx_count;
   logic tx_full;
   logic tx_empty;
   logic src_avail;
   logic [DW-1:0] src_data;
   logic tx_load;
   logic tx_drop;
   logic hold_empty;
   logic hold_empty_q;
   logic [IW-1:0] events;
   logic [IW-1:0] w1c;
   logic [IW-1:0] irq_status;
   logic [IW-1:0] irq_mask;

   function automatic logic is_shadow(input logic [31:0] a);
      is_shadow = ((a - uart_shadow_pkg::SHADOW_BASE) < uart_shadow_pkg::SHADOW_SPAN)
         && (a[1:0] == 2'b00);
   endfunction

   // Write to one of our own registers, low byte lane only
   function automatic logic wr_hit(input logic [31:0] off);
      wr_hit = fire && WRITE && BYTEENABLE[0] && (ADDRESS == off);
   endfunction

   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);

   // ****************************************
   // Avalon-MM slave
   // ****************************************
   assign req = READ || WRITE;
   assign fire = req && !WAITREQUEST;
   assign hit_shadow = is_shadow(ADDRESS);

   // One wait state: the answer is registered so no output is combinational
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         WAITREQUEST <= 1'b1;
      end else begin
         WAITREQUEST <= !(req && WAITREQUEST);
      end
   end

   always_comb begin
      rd_value = '0;
      if (hit_shadow) begin
         rd_value[DW-1:0] = fifo_en ? rx_head : rx_hold;
      end else if (ADDRESS == uart_shadow_pkg::CTRL_OFFSET) begin
         rd_value[uart_shadow_pkg::CTRL_FIFO_EN_BIT] = fifo_en;
         rd_value[uart_shadow_pkg::CTRL_IR_MODE_BIT] = ir_mode;
      end else if (ADDRESS == uart_shadow_pkg::LINE_STATUS_OFFSET) begin
         rd_value[7:0] = line_status;
      end else if (ADDRESS == uart_shadow_pkg::IRQ_STATUS_OFFSET) begin
         rd_value[IW-1:0] = irq_status;
      end else if (ADDRESS == uart_shadow_pkg::IRQ_MASK_OFFSET) begin
         rd_value[IW-1:0] = irq_mask;
      end
   end

   // Data-ready is caught with the data so a FIFO pop never discards an unseen byte; a holding byte overwriting an unread one on the capture edge is popped unread
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         READDATA <= '0;
         rd_ok <= 1'b0;
      end else if (READ && WAITREQUEST) begin
         READDATA <= rd_value;
         rd_ok <= data_ready;
      end
   end

   upper_zero_a: assert property (READDATA[31:DW] == '0)
      else $error("upper read byte not zero");

   bus_ack_a: assert property (req && WAITREQUEST |=> !WAITREQUEST ##1 WAITREQUEST)
      else $error("bus answer not after one wait state");

   // ****************************************
   // Control register
   // ****************************************
   assign fifo_clear = wr_hit(uart_shadow_pkg::CTRL_OFFSET)
      && (WRITEDATA[uart_shadow_pkg::CTRL_FIFO_EN_BIT] != fifo_en);

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         fifo_en <= uart_shadow_pkg::FIFO_EN_RESET;
         ir_mode <= uart_shadow_pkg::IR_MODE_RESET;
      end else if (wr_hit(uart_shadow_pkg::CTRL_OFFSET)) begin
         fifo_en <= WRITEDATA[uart_shadow_pkg::CTRL_FIFO_EN_BIT];
         ir_mode <= WRITEDATA[uart_shadow_pkg::CTRL_IR_MODE_BIT];
      end
   end

   // ****************************************
   // Receive path
   // ****************************************
   assign rx_in_valid = ir_mode ? IR_RX_VALID : UART_RX_VALID;
   assign rx_in_data = ir_mode ? IR_RX_DATA : UART_RX_DATA;
   assign data_ready = fifo_en ? !rx_empty : rx_hold_valid;
   assign rx_pop = fire && READ && hit_shadow && rd_ok;
   assign overrun_event = rx_in_valid && !rx_pop
      && (fifo_en ? rx_full : rx_hold_valid);

   // Single holding byte when FIFOs are off; newest character always wins
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         rx_hold <= uart_shadow_pkg::DATA_RESET;
         rx_hold_valid <= 1'b0;
      end else if (!fifo_en) begin
         if (rx_in_valid) begin
            rx_hold <= rx_in_data;
            rx_hold_valid <= 1'b1;
         end else if (rx_pop) begin
            rx_hold_valid <= 1'b0;
         end
      end else begin
         rx_hold_valid <= 1'b0;
      end
   end

   // Full FIFO refuses the push itself unless it pops on the same edge, which keeps the stored characters
   uart_char_fifo #(
      .WIDTH(DW),
      .DEPTH(FIFO_DEPTH)
   ) rx_fifo (
      .clock(CLOCK),
      .rst(RST),
      .clear(fifo_clear),
      .push(fifo_en && rx_in_valid),
      .pop(fifo_en && rx_pop),
      .din(rx_in_data),
      .head(rx_head),
      .count(rx_count),
      .full(rx_full),
      .empty(rx_empty)
   );

   // Overrun stays until line status is read; a new overrun beats the clear
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         overrun <= 1'b0;
      end else if (overrun_event) begin
         overrun <= 1'b1;
      end else if (fire && READ && ADDRESS == uart_shadow_pkg::LINE_STATUS_OFFSET) begin
         overrun <= 1'b0;
      end
   end

   always_comb begin
      line_status = '0;
      line_status[uart_shadow_pkg::LS_DATA_READY_BIT] = data_ready;
      line_status[uart_shadow_pkg::LS_OVERRUN_BIT] = overrun;
      line_status[uart_shadow_pkg::LS_HOLD_EMPTY_BIT] = hold_empty;
   end

   sequence shadow_read_s;
      READ && WAITREQUEST && is_shadow(ADDRESS);
   endsequence

   sequence answer_s;
      !WAITREQUEST;
   endsequence

   rx_hold_take_a: assert property (!fifo_en && rx_in_valid |=>
      rx_hold_valid && rx_hold == $past(rx_in_data))
      else $error("received character not held");

   hold_overrun_a: assert property (
      !fifo_en && rx_in_valid && rx_hold_valid && !rx_pop |=>
      overrun && irq_status[uart_shadow_pkg::IRQ_OVERRUN_BIT])
      else $error("overwrite without overrun");

   hold_read_a: assert property (
      shadow_read_s ##0 !fifo_en |=> answer_s ##0 (READDATA == {24'h00_0000, $past(rx_hold)}))
      else $error("alias read does not return holding byte");

   head_read_a: assert property (
      shadow_read_s ##0 fifo_en |=> answer_s ##0 (READDATA[DW-1:0] == $past(rx_head)))
      else $error("read does not return FIFO head");

   fifo_keep_a: assert property (
      fifo_en && rx_in_valid && rx_full && !rx_pop && !fifo_clear |=>
      rx_count == $past(rx_count) && overrun)
      else $error("full receive FIFO changed or no overrun");

   // ****************************************
   // Transmit path
   // ****************************************
   assign tx_wr = fire && WRITE && hit_shadow && BYTEENABLE[0];
   assign src_avail = fifo_en ? !tx_empty : tx_hold_valid;
   assign src_data = fifo_en ? tx_head : tx_hold;
   assign tx_load = src_avail && (!(TX_UART_VALID || TX_IR_VALID) || TX_TAKE);
   assign tx_drop = tx_wr && fifo_en && tx_full && !tx_load;
   assign hold_empty = fifo_en ? tx_empty : !tx_hold_valid;

   // A write on the same edge as a load refills the byte just taken
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         tx_hold <= uart_shadow_pkg::DATA_RESET;
         tx_hold_valid <= 1'b0;
      end else if (!fifo_en) begin
         if (tx_wr) begin
            tx_hold <= WRITEDATA[DW-1:0];
            tx_hold_valid <= 1'b1;
         end else if (tx_load) begin
            tx_hold_valid <= 1'b0;
         end
      end else begin
         tx_hold_valid <= 1'b0;
      end
   end

   uart_char_fifo #(
      .WIDTH(DW),
      .DEPTH(FIFO_DEPTH)
   ) tx_fifo (
      .clock(CLOCK),
      .rst(RST),
      .clear(fifo_clear),
      .push(fifo_en && tx_wr),
      .pop(fifo_en && tx_load),
      .din(WRITEDATA[DW-1:0]),
      .head(tx_head),
      .count(tx_count),
      .full(tx_full),
      .empty(tx_empty)
   );

   // Output stage towards the serialiser; the route follows the mode at load
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         TX_DATA <= uart_shadow_pkg::DATA_RESET;
         TX_UART_VALID <= 1'b0;
         TX_IR_VALID <= 1'b0;
      end else if (tx_load) begin
         TX_DATA <= src_data;
         TX_UART_VALID <= !ir_mode;
         TX_IR_VALID <= ir_mode;
      end else if (TX_TAKE) begin
         TX_UART_VALID <= 1'b0;
         TX_IR_VALID <= 1'b0;
      end
   end

   tx_route_a: assert property (tx_load |=>
      TX_DATA == $past(src_data) && TX_IR_VALID == $past(ir_mode)
      && TX_UART_VALID == !$past(ir_mode))
      else $error("transmit byte or route wrong");

   hold_empty_clear_a: assert property (tx_wr && !fifo_en |=> !hold_empty)
      else $error("holding-empty not cleared by write");

   tx_replace_a: assert property (
      tx_wr && !fifo_en |=> tx_hold == $past(WRITEDATA[DW-1:0]))
      else $error("pending byte not replaced");

   tx_depth_a: assert property (
      fifo_en && tx_wr && !tx_full && !fifo_clear |=>
      tx_count == $past(tx_count) + CW'(1) - CW'($past(tx_load)))
      else $error("transmit FIFO refused a byte below depth");

   tx_full_a: assert property (tx_full |-> tx_count == CW'(FIFO_DEPTH))
      else $error("transmit FIFO full below depth");

   tx_drop_a: assert property (tx_drop |=>
      tx_count == $past(tx_count) && irq_status[uart_shadow_pkg::IRQ_TX_DROP_BIT])
      else $error("write to full FIFO not discarded");

   // ****************************************
   // Interrupts
   // ****************************************
   always_comb begin
      events = '0;
      events[uart_shadow_pkg::IRQ_RX_CHAR_BIT] = rx_in_valid && !overrun_event;
      events[uart_shadow_pkg::IRQ_OVERRUN_BIT] = overrun_event;
      events[uart_shadow_pkg::IRQ_TX_DROP_BIT] = tx_drop;
      events[uart_shadow_pkg::IRQ_HOLD_EMPTY_BIT] = hold_empty && !hold_empty_q;
   end

   assign w1c = wr_hit(uart_shadow_pkg::IRQ_STATUS_OFFSET) ? WRITEDATA[IW-1:0] : '0;

   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         irq_status <= '0;
         hold_empty_q <= 1'b1;
      end else begin
         irq_status <= (irq_status & ~w1c) | events;
         hold_empty_q <= hold_empty;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         irq_mask <= uart_shadow_pkg::IRQ_MASK_RESET;
      end else if (wr_hit(uart_shadow_pkg::IRQ_MASK_OFFSET)) begin
         irq_mask <= WRITEDATA[IW-1:0];
      end
   end

   // Registered output costs one cycle of interrupt latency
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(irq_status & irq_mask);
      end
   end

   irq_level_a: assert property (|(irq_status & irq_mask) |=> IRQ)
      else $error("interrupt not raised");

endmodule

/* File: tb/uart_far_end.sv */
// Far-end serial partner model: sends received characters, takes transmitted ones
`timescale 1ns/1ps
module uart_far_end (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Pacing from the bench
   input wire logic stall,
   input wire logic slow,
   // Characters towards the port
   output logic uart_valid,
   output logic [7:0] uart_data,
   output logic ir_valid,
   output logic [7:0] ir_data,
   // Characters from the port
   input wire logic tx_uart_valid,
   input wire logic tx_ir_valid,
   input wire logic [7:0] tx_data,
   output logic tx_take
);
   // ****************************************
   // Receive side stimulus
   // ****************************************
   logic [8:0] got[$];

   initial begin
      uart_valid = 1'b0;
      uart_data = 8'h00;
      ir_valid = 1'b0;
      ir_data = 8'h00;
      tx_take = 1'b0;
   end

   // One character a pulse; idle data of the channel just sent shows garbage, never its last byte
   task automatic send(input logic ir, input logic [7:0] ch);
      @(posedge clock);
      if (ir) begin
         ir_valid <= 1'b1;
         ir_data <= ch;
      end else begin
         uart_valid <= 1'b1;
         uart_data <= ch;
      end
      @(posedge clock);
      ir_valid <= 1'b0;
      uart_valid <= 1'b0;
      ir_data <= ~ir_data;
      uart_data <= ~uart_data;
   endtask

   // ****************************************
   // Transmit side sink
   // ****************************************
   // Slow mode takes every other cycle to exercise the stage holding
   always @(posedge clock) begin
      if (rst) begin
         tx_take <= 1'b0;
      end else begin
         tx_take <= !stall && (!slow || !tx_take);
      end
   end

   always @(posedge clock) begin
      if (!rst && tx_take && (tx_uart_valid || tx_ir_valid)) begin
         got.push_back({tx_ir_valid, tx_data});
      end
   end
endmodule

/* File: tb/uart_shadow_data_port_tb_top.sv */
// Self-checking bench for the UART shadow data port
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) begin \
         n_errors++; \
         $display("ERROR %s expected %h seen %h", what, exp, got); \
      end \
   end
module uart_shadow_data_port_tb_top;
   // ****************************************
   // Signals and instances
   // ****************************************
   localparam int DEPTH = 4;
   localparam logic [31:0] SH12 = uart_shadow_pkg::SHADOW12_OFFSET;
   localparam logic [31:0] LS = uart_shadow_pkg::LINE_STATUS_OFFSET;
   localparam logic [31:0] CTRL = uart_shadow_pkg::CTRL_OFFSET;
   localparam logic [31:0] IST = uart_shadow_pkg::IRQ_STATUS_OFFSET;
   localparam logic [31:0] IMSK = uart_shadow_pkg::IRQ_MASK_OFFSET;
   logic CLOCK, RST, READ, WRITE, WAITREQUEST, IRQ, TX_TAKE, TX_UART_VALID, TX_IR_VALID;
   logic UART_RX_VALID, IR_RX_VALID, stall, slow;
   logic [31:0] ADDRESS, WRITEDATA, READDATA;
   logic [3:0] BYTEENABLE;
   logic [7:0] UART_RX_DATA, IR_RX_DATA, TX_DATA;
   logic [8:0] exp_q[$];
   int n_errors = 0;
   int n_tests = 0;
   int cycles = 0;

   uart_shadow_data_port #(.FIFO_DEPTH(DEPTH)) uart_shadow_data_port_i (.CLOCK(CLOCK),
      .RST(RST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
      .BYTEENABLE(BYTEENABLE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
      .UART_RX_VALID(UART_RX_VALID), .UART_RX_DATA(UART_RX_DATA), .IR_RX_VALID(IR_RX_VALID),
      .IR_RX_DATA(IR_RX_DATA), .TX_TAKE(TX_TAKE), .TX_UART_VALID(TX_UART_VALID),
      .TX_IR_VALID(TX_IR_VALID), .TX_DATA(TX_DATA), .IRQ(IRQ));

   uart_far_end uart_far_end_i (.clock(CLOCK), .rst(RST), .stall(stall), .slow(slow),
      .uart_valid(UART_RX_VALID), .uart_data(UART_RX_DATA), .ir_valid(IR_RX_VALID),
      .ir_data(IR_RX_DATA), .tx_uart_valid(TX_UART_VALID), .tx_ir_valid(TX_IR_VALID),
      .tx_data(TX_DATA), .tx_take(TX_TAKE));

   initial begin
      CLOCK = 1'b0;
      forever #25 CLOCK = ~CLOCK;
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic bus_write(input logic [31:0] a, input logic [31:0] d,
                            input logic [3:0] be = 4'hF);
      @(posedge CLOCK);
      ADDRESS <= a;
      WRITEDATA <= d;
      BYTEENABLE <= be;
      WRITE <= 1'b1;
      do @(posedge CLOCK); while (WAITREQUEST !== 1'b0);
      WRITE <= 1'b0;
   endtask

   task automatic bus_read(input logic [31:0] a, output logic [31:0] rd);
      @(posedge CLOCK);
      ADDRESS <= a;
      READ <= 1'b1;
      do @(posedge CLOCK); while (WAITREQUEST !== 1'b0);
      rd = READDATA;
      READ <= 1'b0;
   endtask

   task automatic check_read(input logic [31:0] a, input logic [31:0] exp, input string what);
      logic [31:0] rd;
      bus_read(a, rd);
      `CHECK(what, exp, rd)
   endtask

   // Waits for the expected bytes, then a few cycles more to catch extras
   task automatic tx_drain;
      int k;
      k = 0;
      while (uart_far_end_i.got.size() < exp_q.size() && k < 200) begin
         @(posedge CLOCK);
         k++;
      end
      repeat (4) @(posedge CLOCK);
      `CHECK("tx count", exp_q.size(), uart_far_end_i.got.size())
      foreach (exp_q[i]) begin
         if (i < uart_far_end_i.got.size()) `CHECK("tx byte", exp_q[i], uart_far_end_i.got[i])
      end
      exp_q.delete();
      uart_far_end_i.got.delete();
   endtask

   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      check_read(SH12, 32'h0000_0000, "shadow reset");
      check_read(LS, 32'h0000_0020, "line status reset");
      check_read(CTRL, 32'h0000_0000, "ctrl reset");
      check_read(IMSK, 32'h0000_0000, "mask reset");
      check_read(32'h5000_1200, 32'h0000_0000, "unmapped read");
      `CHECK("irq reset", 1'b0, IRQ)
   endtask

   task automatic t_rx_plain;
      uart_far_end_i.send(1'b0, 8'h81);
      check_read(LS, 32'h0000_0021, "data ready");
      check_read(SH12, 32'h0000_0081, "rx char");
      uart_far_end_i.send(1'b0, 8'h12);
      uart_far_end_i.send(1'b0, 8'h34);
      check_read(LS, 32'h0000_0023, "rx overrun");
      check_read(SH12, 32'h0000_0034, "overwritten char");
      check_read(LS, 32'h0000_0020, "flags after read");
   endtask

   task automatic t_ir;
      bus_write(CTRL, 32'h0000_0002);
      uart_far_end_i.send(1'b0, 8'h11);
      uart_far_end_i.send(1'b1, 8'h5A);
      check_read(SH12, 32'h0000_005A, "ir char");
      check_read(LS, 32'h0000_0020, "serial ignored");
      bus_write(SH12, 32'h0000_00C7);
      exp_q = '{9'h1C7};
      tx_drain;
      bus_write(CTRL, 32'h0000_0000);
   endtask

   task automatic t_tx_plain;
      stall <= 1'b1;
      check_read(LS, 32'h0000_0020, "holding empty");
      bus_write(SH12, 32'hFFFF_FFA1);
      check_read(LS, 32'h0000_0020, "stage took byte");
      bus_write(SH12, 32'h0000_00B2);
      check_read(LS, 32'h0000_0000, "holding full");
      bus_write(SH12, 32'h0000_00C3);
      bus_write(SH12, 32'h0000_00D4, 4'hE);
      stall <= 1'b0;
      exp_q = '{9'h0A1, 9'h0C3};
      tx_drain;
   endtask

   task automatic t_rx_fifo;
      bus_write(CTRL, 32'h0000_0001);
      for (int i = 0; i <= DEPTH; i++) uart_far_end_i.send(1'b0, 8'(8'h60 + i));
      check_read(LS, 32'h0000_0023, "rx fifo overrun");
      for (int i = 0; i < DEPTH; i++) check_read(SH12, 32'(8'h60 + i), "rx fifo head");
      check_read(LS, 32'h0000_0020, "rx fifo empty");
      for (int i = 0; i < 16; i++) begin
         uart_far_end_i.send(1'b0, 8'(i + 8'h90));
         check_read(uart_shadow_pkg::SHADOW_BASE + 32'(i * 4), 32'(i + 8'h90), "alias");
      end
   endtask

   task automatic t_tx_fifo;
      logic [31:0] rd;
      stall <= 1'b1;
      bus_write(IST, 32'h0000_000F);
      for (int i = 0; i < DEPTH + 2; i++) bus_write(SH12, 32'(8'h40 + i));
      bus_read(IST, rd);
      `CHECK("tx drop flag", 1'b1, rd[uart_shadow_pkg::IRQ_TX_DROP_BIT])
      for (int i = 0; i <= DEPTH; i++) exp_q.push_back(9'(8'h40 + i));
      slow <= 1'b1;
      stall <= 1'b0;
      tx_drain;
      slow <= 1'b0;
   endtask

   task automatic t_irq;
      bus_write(IST, 32'h0000_000F);
      bus_write(IMSK, 32'h0000_0001);
      uart_far_end_i.send(1'b0, 8'h77);
      repeat (2) @(posedge CLOCK);
      `CHECK("irq raised", 1'b1, IRQ)
      bus_write(IMSK, 32'h0000_0000);
      repeat (2) @(posedge CLOCK);
      `CHECK("irq masked", 1'b0, IRQ)
      bus_write(IMSK, 32'h0000_0001);
      repeat (2) @(posedge CLOCK);
      `CHECK("irq unmasked", 1'b1, IRQ)
      bus_write(IST, 32'h0000_0001);
      repeat (2) @(posedge CLOCK);
      `CHECK("irq cleared", 1'b0, IRQ)
   endtask

   // ****************************************
   // Main sequence and hang guard
   // ****************************************
   initial begin
      RST = 1'b1;
      READ = 1'b0;
      WRITE = 1'b0;
      ADDRESS = 32'h0000_0000;
      WRITEDATA = 32'h0000_0000;
      BYTEENABLE = 4'hF;
      stall = 1'b0;
      slow = 1'b0;
      repeat (2) @(posedge CLOCK);
      RST <= 1'b0;
      t_reset;
      t_rx_plain;
      t_ir;
      t_tx_plain;
      t_rx_fifo;
      t_tx_fifo;
      t_irq;
      conclude;
   end

   // Whole run needs a few hundred cycles; far more means a hang
   always @(posedge CLOCK) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         conclude;
      end
   end
endmodule
